// [core/lcd_input_timing_config.sv]
// input timing generator configuration and line/frame sequencing
`timescale 1ns/1ps
`include "lcd_timing_params.svh"
module lcd_input_timing_config #(
  parameter int DATA_W = 18,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire lcd_timing_pkg::cmd_t CMD_I,
  output logic [7:0] CMD_RDATA_O,
  output logic CMD_RVALID_O,
  input wire logic HSYNC_N_I,
  input wire logic VSYNC_N_I,
  input wire logic DOTCLK_I,
  input wire logic [DATA_W-1:0] PIX_I,
  output logic [DATA_W-1:0] PIX_DATA_O,
  output logic PIX_VALID_O,
  input wire logic PIX_READY_I,
  output logic SCAN_DIR_OUT_O,
  output logic GATE_START_PULSE_OUT_O,
  output logic GATE_SHIFT_O,
  output logic GATE_OUT_ENABLE_FIRST_O,
  output logic COMMON_WAVE_OUT_O,
  output logic RED_SWITCH_OUT_O,
  output logic GREEN_SWITCH_OUT_O,
  output logic BLUE_SWITCH_OUT_O,
  output logic AMP_DRIVE_O,
  output logic SRC_ASCEND_O,
  output logic LOW_POWER_O,
  output logic EIGHT_COLOR_O,
  output logic FRAME_INV_O,
  output logic WHITE_SCREEN_O,
  output logic QUARTER_O
);
  import lcd_timing_pkg::*;

  typedef struct packed {
    logic [7:0] hstart;
    logic [7:0] vstart;
    logic [1:0] vpix;
    logic stby;
    logic quarter;
  } frm_t;
  typedef struct packed {
    logic eight;
    logic lowpow;
    logic frameinv;
  } lin_t;
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] vs;
    logic [2:0] dc;
    logic [DATA_W-1:0] pd1;
    logic [DATA_W-1:0] pd2;
    logic [7:0] sel;
    cfg_t cfg;
    frm_t frm;
    lin_t lin;
    logic [8:0] dot_cnt;
    logic [9:0] pix_cnt;
    logic [7:0] line_cnt;
    phase_t phase;
    logic [7:0] ph_cnt;
    logic amp;
    logic com;
    logic com_out;
    logic goe;
    logic gstb;
    logic gshift;
    logic pend;
    logic dup;
    logic [DATA_W-1:0] pdat;
    logic [7:0] rdata;
    logic rvalid;
  } st_t;

  st_t s_q, s_d;
  logic fifo_ready;

  if (DATA_W < 1 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("lcd_input_timing_config needs DATA_W>=1, FIFO_DEPTH>=2");
  end

  // codes below the floor clamp up to it
  function automatic logic [7:0] start_eff(input logic [7:0] code,
                                           input logic [7:0] floor_v);
    start_eff = (code < floor_v) ? floor_v : code;
  endfunction

  function automatic logic [9:0] npix(input logic [1:0] code);
    case (code)
      2'h0: npix = `NPIX_0;
      2'h1: npix = `NPIX_1;
      2'h2: npix = `NPIX_2;
      default: npix = `NPIX_3;
    endcase
  endfunction

  function automatic logic [7:0] rd_reg(input cfg_t c, input logic [7:0] a);
    case (a)
      `RN_HSTART: rd_reg = c.hstart;
      `RN_VSTART: rd_reg = c.vstart;
      `RN_VPIX: rd_reg = c.vpix;
      `RN_STBY: rd_reg = c.stby;
      `RN_EIGHT: rd_reg = c.eight;
      `RN_SETUP: rd_reg = c.setup;
      `RN_AMP: rd_reg = c.amp;
      `RN_QUARTER: rd_reg = c.quarter;
      default: rd_reg = 8'h00;
    endcase
  endfunction

  logic hfall, vfall, dcrise;
  logic [7:0] h_eff, v_eff, nline;
  assign hfall = s_q.hs[2] && !s_q.hs[1];
  assign vfall = s_q.vs[2] && !s_q.vs[1];
  assign dcrise = s_q.dc[1] && !s_q.dc[2];
  assign h_eff = start_eff(s_q.frm.hstart, `HSTART_MIN);
  assign v_eff = start_eff(s_q.frm.vstart, `VSTART_MIN);
  assign nline = (s_q.line_cnt == 8'hFF) ? s_q.line_cnt
                                         : s_q.line_cnt + 8'h01;

  always_comb begin
    s_d = s_q;
    s_d.hs = {s_q.hs[1:0], HSYNC_N_I};
    s_d.vs = {s_q.vs[1:0], VSYNC_N_I};
    s_d.dc = {s_q.dc[1:0], DOTCLK_I};
    s_d.pd1 = PIX_I;
    s_d.pd2 = s_q.pd1;
    s_d.rvalid = 1'b0;
    s_d.gstb = 1'b0;
    s_d.gshift = 1'b0;

    // command port: a0 low selects a register, a0 high writes it
    if (CMD_I.wr && !CMD_I.a0)
      s_d.sel = CMD_I.data;
    if (CMD_I.wr && CMD_I.a0) begin
      case (s_q.sel)
        `RN_HSTART: s_d.cfg.hstart = CMD_I.data;
        `RN_VSTART: s_d.cfg.vstart = CMD_I.data;
        `RN_VPIX: s_d.cfg.vpix = CMD_I.data;
        `RN_STBY: s_d.cfg.stby = CMD_I.data & `BIT0_MASK;
        `RN_EIGHT: s_d.cfg.eight = CMD_I.data & `BIT0_MASK;
        `RN_SETUP: s_d.cfg.setup = CMD_I.data & `SETUP_MASK;
        `RN_AMP: s_d.cfg.amp = CMD_I.data & `AMP_MASK;
        `RN_QUARTER: s_d.cfg.quarter = CMD_I.data & `BIT0_MASK;
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    if (CMD_I.rd) begin
      s_d.rdata = rd_reg(s_q.cfg, s_q.sel);
      s_d.rvalid = 1'b1;
    end

    // pending pixel drains into the fifo; a duplicate follows it
    if (s_q.pend && fifo_ready) begin
      s_d.pend = s_q.dup;
      s_d.dup = 1'b0;
    end

    if (vfall) begin
      // frame-timed settings only move at the frame boundary
      s_d.frm.hstart = s_q.cfg.hstart;
      s_d.frm.vstart = s_q.cfg.vstart;
      s_d.frm.vpix = s_q.cfg.vpix[1:0];
      s_d.frm.stby = s_q.cfg.stby[0];
      s_d.frm.quarter = s_q.cfg.quarter[0];
      s_d.line_cnt = 8'h00;
      // a count left from the last line would exceed a smaller new limit
      s_d.pix_cnt = 10'h000;
      if (s_q.lin.frameinv)
        s_d.com = !s_q.com;
    end

    if (hfall) begin
      s_d.lin.eight = s_q.cfg.eight[0];
      s_d.lin.lowpow = !s_q.cfg.setup[`B_LOWPOW];
      s_d.lin.frameinv = s_q.cfg.setup[`B_FRAMEINV];
      s_d.dot_cnt = 9'h000;
      s_d.pix_cnt = 10'h000;
      if (!vfall)
        s_d.line_cnt = nline;
      s_d.phase = PH_RED;
      s_d.ph_cnt = 8'h00;
      if (!s_q.lin.frameinv)
        s_d.com = !s_q.com;
      s_d.gstb = !vfall && nline == v_eff;
      s_d.gshift = !vfall && nline >= v_eff;
    end else if (dcrise) begin
      if (s_q.dot_cnt != 9'h1FF)
        s_d.dot_cnt = s_q.dot_cnt + 9'h001;
      if (s_q.phase != PH_IDLE) begin
        if (s_q.ph_cnt == `SW_PHASE_LEN - 8'h01) begin
          s_d.ph_cnt = 8'h00;
          case (s_q.phase)
            PH_RED: s_d.phase = PH_GREEN;
            PH_GREEN: s_d.phase = PH_BLUE;
            default: s_d.phase = PH_IDLE;
          endcase
          // quarter mode scans a second gate line as the green phase ends
          if (s_q.phase == PH_GREEN && s_q.frm.quarter &&
              s_q.line_cnt >= v_eff)
            s_d.gshift = 1'b1;
        end else begin
          s_d.ph_cnt = s_q.ph_cnt + 8'h01;
        end
      end
      // dot count after this edge must exceed the start delay
      if (s_q.line_cnt >= v_eff && !s_q.frm.stby &&
          s_q.dot_cnt >= {1'b0, h_eff} &&
          s_q.pix_cnt < npix(s_q.frm.vpix)) begin
        s_d.pix_cnt = s_q.pix_cnt + (s_q.frm.quarter ? 10'h002
                                                      : 10'h001);
        // a pixel arriving while the fifo stalls is lost
        if (!s_d.pend) begin
          s_d.pend = 1'b1;
          s_d.pdat = s_q.pd2;
          s_d.dup = s_q.frm.quarter;
        end
      end
    end

    // amp drive opens at the start of each colour phase
    s_d.amp = s_d.phase != PH_IDLE &&
              s_d.ph_cnt < {3'h0, s_d.cfg.amp[4:0]};
    // forcing follows the stored bit, so a low bit always wins next cycle
    s_d.goe = s_d.line_cnt >= v_eff &&
              s_q.cfg.setup[`B_GOEN];
    s_d.com_out = s_d.com && s_q.cfg.setup[`B_COMSQ] &&
                  !s_d.frm.stby;
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_q <= '0;
      s_q.hs <= 3'h7;
      s_q.vs <= 3'h7;
      s_q.phase <= PH_IDLE;
      s_q.cfg <= '{`RST_HSTART, `RST_VSTART, `RST_VPIX, `RST_STBY,
                   `RST_EIGHT, `RST_SETUP, `RST_AMP, `RST_QUARTER};
      s_q.frm <= '{`RST_HSTART, `RST_VSTART, 2'h0, 1'b0, 1'b0};
      s_q.lin <= '{1'b0, 1'b0, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  pix_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .in_valid_i(s_q.pend),
    .in_ready_o(fifo_ready),
    .in_data_i(s_q.pdat),
    .out_valid_o(PIX_VALID_O),
    .out_ready_i(PIX_READY_I),
    .out_data_o(PIX_DATA_O)
  );

  assign CMD_RDATA_O = s_q.rdata;
  assign CMD_RVALID_O = s_q.rvalid;
  assign SCAN_DIR_OUT_O = s_q.cfg.setup[`B_SCANDIR];
  assign SRC_ASCEND_O = s_q.cfg.setup[`B_SRCORD];
  assign GATE_START_PULSE_OUT_O = s_q.gstb;
  assign GATE_SHIFT_O = s_q.gshift;
  assign GATE_OUT_ENABLE_FIRST_O = s_q.goe;
  assign COMMON_WAVE_OUT_O = s_q.com_out;
  assign RED_SWITCH_OUT_O = s_q.phase[1];
  assign GREEN_SWITCH_OUT_O = s_q.phase[2];
  assign BLUE_SWITCH_OUT_O = s_q.phase[3];
  assign AMP_DRIVE_O = s_q.amp;
  assign LOW_POWER_O = s_q.lin.lowpow;
  assign EIGHT_COLOR_O = s_q.lin.eight;
  assign FRAME_INV_O = s_q.lin.frameinv;
  assign WHITE_SCREEN_O = s_q.frm.stby;
  assign QUARTER_O = s_q.frm.quarter;

  a_hstart_floor : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    (dcrise && !hfall && s_q.dot_cnt < 9'h004) |=>
      !s_q.pend || $past(s_q.pend))
    else $error("pixel taken before four dot clocks");
  a_vstart_floor : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    (hfall && !vfall && s_q.line_cnt == 8'h00) |=> !s_q.gshift)
    else $error("gate scan on first line after vsync");
  a_pixel_limit : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    s_q.pix_cnt <= npix(s_q.frm.vpix) + 10'h001)
    else $error("valid pixel count exceeded");
  a_frame_shadow : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    !$stable(s_q.frm) |-> $past(vfall))
    else $error("frame setting moved outside frame start");
  a_standby_white : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    WHITE_SCREEN_O |=> !COMMON_WAVE_OUT_O || !WHITE_SCREEN_O)
    else $error("common output toggles in standby");
  a_line_shadow : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    !$stable(FRAME_INV_O) |-> $past(hfall))
    else $error("inversion changed outside line start");
  a_goe_forced : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    !s_q.cfg.setup[`B_GOEN] |=> !GATE_OUT_ENABLE_FIRST_O)
    else $error("first gate enable not forced low");
  a_com_held : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    !s_q.cfg.setup[`B_COMSQ] |=> !COMMON_WAVE_OUT_O)
    else $error("common square wave not held low");
  a_amp_start : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    ($rose(RED_SWITCH_OUT_O) && s_q.cfg.amp != 8'h00) |-> AMP_DRIVE_O)
    else $error("amp drive missing at red switch start");
  a_quarter_dup : assert property (
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    ($rose(s_q.pend) && s_q.dup) |-> ##[1:40] (s_q.pend && !s_q.dup))
    else $error("quarter duplicate pixel not issued");
endmodule // lcd_input_timing_config

// [core/lcd_timing_params.svh]
// constants for the lcd input timing configuration block
`ifndef LCD_TIMING_PARAMS_SVH
`define LCD_TIMING_PARAMS_SVH
`define RN_HSTART 8'h01
`define RN_VSTART 8'h02
`define RN_VPIX 8'h03
`define RN_STBY 8'h04
`define RN_EIGHT 8'h05
`define RN_SETUP 8'h06
`define RN_AMP 8'h08
`define RN_QUARTER 8'h09
`define RST_HSTART 8'h0A
`define RST_VSTART 8'h02
`define RST_VPIX 8'h00
`define RST_STBY 8'h00
`define RST_EIGHT 8'h00
`define RST_SETUP 8'h02
`define RST_AMP 8'h0E
`define RST_QUARTER 8'h00
`define HSTART_MIN 8'h04
`define VSTART_MIN 8'h02
`define NPIX_0 10'h0F0
`define NPIX_1 10'h0F4
`define NPIX_2 10'h1E0
`define NPIX_3 10'h1E8
`define SETUP_MASK 8'h3F
`define BIT0_MASK 8'h01
`define AMP_MASK 8'h1F
`define B_LOWPOW 0
`define B_SCANDIR 1
`define B_SRCORD 2
`define B_FRAMEINV 3
`define B_GOEN 4
`define B_COMSQ 5
`define SW_PHASE_LEN 8'h0F
`endif

// [core/lcd_timing_pkg.sv]
// types shared by the lcd input timing configuration block
package lcd_timing_pkg;
  typedef struct packed {
    logic [7:0] hstart;
    logic [7:0] vstart;
    logic [7:0] vpix;
    logic [7:0] stby;
    logic [7:0] eight;
    logic [7:0] setup;
    logic [7:0] amp;
    logic [7:0] quarter;
  } cfg_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic a0;
    logic [7:0] data;
  } cmd_t;
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_RED = 4'b0010,
    PH_GREEN = 4'b0100,
    PH_BLUE = 4'b1000
  } phase_t;
endpackage

// [core/pix_fifo.sv]
// pixel fifo with registered output stage
`timescale 1ns/1ps
module pix_fifo #(
  parameter int W = 18,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } fst_t;
  fst_t s_q, s_d;
  logic [W-1:0] mem [DEPTH];
  logic push, pop, load;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("pix_fifo depth must be a power of two, at least 2");
  end

  assign in_ready_o = s_q.cnt != (AW+1)'(DEPTH);
  assign push = in_valid_i && in_ready_o;
  // output stage refills whenever it is empty or being taken
  assign load = (!s_q.ov || out_ready_i) && s_q.cnt != '0;
  assign pop = load;

  always_comb begin
    s_d = s_q;
    if (push)
      s_d.wp = s_q.wp + 1'b1;
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
      s_d.od = mem[s_q.rp];
    end
    if (s_q.ov && out_ready_i)
      s_d.ov = 1'b0;
    if (load)
      s_d.ov = 1'b1;
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  always_ff @(posedge clk_i) begin
    if (push)
      mem[s_q.wp] <= in_data_i;
  end

  assign out_valid_o = s_q.ov;
  assign out_data_o = s_q.od;
endmodule // pix_fifo

// [bench/lcd_host_model.sv]
// host display controller model: sync pulses, dot clock and pixel words
`timescale 1ns/1ps
module lcd_host_model #(
  parameter int DATA_W = 18
) (
  output logic hsync_n_o,
  output logic vsync_n_o,
  output logic dotclk_o,
  output logic [DATA_W-1:0] pix_o
);
  initial begin
    hsync_n_o = 1'b1;
    vsync_n_o = 1'b1;
    dotclk_o = 1'b0;
    pix_o = '0;
  end
  // word is {line, dot} so the bench can tell which rise was taken
  task automatic line(input int ln, input int dots);
    hsync_n_o = 1'b0;
    #64 hsync_n_o = 1'b1;
    for (int d = 0; d < dots; d++) begin
      pix_o = DATA_W'({ln[7:0], d[9:0]});
      #32 dotclk_o = 1'b1;
      #32 dotclk_o = 1'b0;
    end
    // the word is stale once the last rise has passed
    pix_o = ~pix_o;
    #64;
  endtask
  // dot clock stands still between lines and between frames
  task automatic frame(input int pre, input int dots);
    vsync_n_o = 1'b0;
    #64 vsync_n_o = 1'b1;
    for (int l = 0; l <= pre; l++) begin
      line(l, (l < pre) ? 8 : dots);
    end
  endtask
endmodule // lcd_host_model

// [bench/lcd_input_timing_config_tb.sv]
// self-checking bench for the lcd input timing configuration block
`timescale 1ns/1ps
`include "lcd_timing_params.svh"
module lcd_input_timing_config_tb;
  import lcd_timing_pkg::*;
  typedef struct packed {
    logic [7:0] hs, vs, vp, q, amp, su;
    logic [9:0] dots;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cmd_t cmd = '0;
  logic ready = 1'b1;
  logic hs_n, vs_n, dck, rvalid, pvalid, dir, shift, goe_o, com_o;
  logic rsw, gsw, bsw, amp_o, asc, lowp, eight, finv, white, quart;
  logic [17:0] pix, pdata, w0, w1;
  logic [7:0] rdata, v;
  logic [7:0] amp_cfg = 8'h0E;
  logic [2:0] sw_q = 3'h0;
  logic hs_q = 1'b1;
  logic goe, com, cw, gstb;
  int mismatches = 0, tests_run = 0, cyc = 0, nw, nsh, ac, hd, pre, n, nst;
  row_t r;
  logic [9:0] lim [4] = '{`NPIX_0, `NPIX_1, `NPIX_2, `NPIX_3};
  row_t rows [5] = '{
    '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 10'h0FA},
    '{8'h05, 8'h03, 8'h01, 8'h00, 8'h0E, 8'h12, 10'h0FC},
    '{8'h0A, 8'h02, 8'h00, 8'h00, 8'h0C, 8'h22, 10'h0F8},
    '{8'h04, 8'h02, 8'h02, 8'h01, 8'h01, 8'h02, 10'h0FA},
    '{8'h04, 8'h02, 8'h03, 8'h00, 8'h0E, 8'h02, 10'h1EE}};
  logic [23:0] regs [9] = '{24'h01FFFF, 24'h04FF01, 24'h05FE00,
    24'h06FF3F, 24'h08FF1F, 24'h09FF01, 24'h07FF00,
    24'h00AA00, 24'h020303};
  logic [15:0] dflt [8] = '{{`RN_HSTART, `RST_HSTART},
    {`RN_VSTART, `RST_VSTART}, {`RN_VPIX, `RST_VPIX},
    {`RN_STBY, `RST_STBY}, {`RN_EIGHT, `RST_EIGHT},
    {`RN_SETUP, `RST_SETUP}, {`RN_AMP, `RST_AMP},
    {`RN_QUARTER, `RST_QUARTER}};

  lcd_input_timing_config i_dut (
    .REF_CLK_I(clk), .RSTN_I(rst_n), .CMD_I(cmd), .CMD_RDATA_O(rdata),
    .CMD_RVALID_O(rvalid), .HSYNC_N_I(hs_n), .VSYNC_N_I(vs_n),
    .DOTCLK_I(dck), .PIX_I(pix), .PIX_DATA_O(pdata), .PIX_VALID_O(pvalid),
    .PIX_READY_I(ready), .SCAN_DIR_OUT_O(dir), .GATE_START_PULSE_OUT_O(gstb),
    .GATE_SHIFT_O(shift), .GATE_OUT_ENABLE_FIRST_O(goe_o),
    .COMMON_WAVE_OUT_O(com_o), .RED_SWITCH_OUT_O(rsw),
    .GREEN_SWITCH_OUT_O(gsw), .BLUE_SWITCH_OUT_O(bsw), .AMP_DRIVE_O(amp_o),
    .SRC_ASCEND_O(asc), .LOW_POWER_O(lowp), .EIGHT_COLOR_O(eight),
    .FRAME_INV_O(finv), .WHITE_SCREEN_O(white), .QUARTER_O(quart));
  lcd_host_model i_host (.hsync_n_o(hs_n), .vsync_n_o(vs_n),
    .dotclk_o(dck), .pix_o(pix));

  initial forever #2 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) cmd = '{1'b1, 1'b0, 1'b0, a};
    @(negedge clk) cmd = '{1'b1, 1'b0, 1'b1, d};
    @(negedge clk) cmd = '0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) cmd = '{1'b1, 1'b0, 1'b0, a};
    @(negedge clk) cmd = '{1'b0, 1'b1, 1'b0, 8'h00};
    @(negedge clk) cmd = '0;
    check(rvalid, 1'b1);
    d = rdata;
  endtask
  task automatic run_frame(input int p, input int dots);
    @(negedge clk);
    nw = 0;
    nsh = 0;
    goe = 1'b0;
    com = 1'b0;
    cw = 1'b0;
    nst = 0;
    i_host.frame(p, dots);
    repeat (40) @(negedge clk);
  endtask

  always @(posedge clk) begin
    if (pvalid && ready) begin
      if (nw == 0) w0 = pdata;
      if (nw == 1) w1 = pdata;
      nw++;
    end
    nsh += shift;
    goe |= goe_o;
    com |= com_o;
    // standby only starts at the frame edge, so watch the common only then
    cw |= com_o & white;
    nst += gstb;
    ac = (hs_q && !hs_n) ? 0 : ac + amp_o;
    hs_q = hs_n;
    // drive must come up together with each colour switch
    if ((({rsw, gsw, bsw} & ~sw_q) != 3'h0) && amp_cfg != 8'h00)
      check(amp_o, 1'b1);
    sw_q = {rsw, gsw, bsw};
    cyc++;
    if (cyc > 90000) begin
      mismatches++;
      $display("[FAIL] %0t run too long", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      // start delay counts dot clocks (two pixels each in quarter mode), so it is written at full count
      wr_reg(`RN_HSTART, r.hs);
      wr_reg(`RN_VSTART, r.vs);
      wr_reg(`RN_VPIX, r.vp);
      wr_reg(`RN_QUARTER, r.q);
      wr_reg(`RN_AMP, r.amp);
      wr_reg(`RN_SETUP, r.su);
      amp_cfg = r.amp;
      check(dir, r.su[1]);
      check(asc, r.su[2]);
      hd = (r.hs < `HSTART_MIN) ? `HSTART_MIN : r.hs;
      pre = ((r.vs < `VSTART_MIN) ? `VSTART_MIN : r.vs) - 1;
      run_frame(pre, r.dots);
      n = r.q[0] ? 2 * (r.dots - hd) : r.dots - hd;
      if (n > lim[r.vp]) n = lim[r.vp];
      check(nw, n);
      check(w0, {pre[7:0], hd[9:0]});
      if (r.q[0]) check(w1, {pre[7:0], hd[9:0]});
      check(nsh, r.q[0] ? 2 : 1);
      check(nst, 1);
      check(quart, r.q[0]);
      check(goe, r.su[4]);
      check(com, r.su[5]);
      check((ac + 48 >= 48 * r.amp) && (ac <= 48 * r.amp + 48), 1'b1);
      done("frame row");
    end
    wr_reg(`RN_HSTART, 8'h06);
    wr_reg(`RN_VPIX, 8'h00);
    wr_reg(`RN_SETUP, 8'h22);
    fork
      run_frame(1, 250);
      begin
        repeat (2000) @(negedge clk);
        wr_reg(`RN_HSTART, 8'h10);
        wr_reg(`RN_STBY, 8'h01);
      end
    join
    check(nw, 240);
    check(w0, {8'h01, 10'h006});
    check(white, 1'b0);
    run_frame(1, 250);
    check(nw, 0);
    check(white, 1'b1);
    check(cw, 1'b0);
    // supplies are back on before normal mode is restored
    wr_reg(`RN_STBY, 8'h00);
    run_frame(1, 250);
    check(w0, {8'h01, 10'h010});
    check(nw, 234);
    check(white, 1'b0);
    done("standby");
    wr_reg(`RN_EIGHT, 8'h01);
    wr_reg(`RN_SETUP, 8'h39);
    check(dir, 1'b0);
    check({eight, finv, lowp}, 3'b001);
    ready = 1'b0;
    run_frame(1, 250);
    check({eight, finv, lowp}, 3'b110);
    ready = 1'b1;
    repeat (60) @(negedge clk);
    // sink stalled the whole line: only what the buffer held survives
    check((nw >= 16) && (nw <= 18), 1'b1);
    check(w0, {8'h01, 10'h010});
    check(pvalid, 1'b0);
    done("stall");
    foreach (regs[i]) begin
      wr_reg(regs[i][23:16], regs[i][15:8]);
      rd_reg(regs[i][23:16], v);
      check(v, regs[i][7:0]);
    end
    check({dir, asc}, 2'b11);
    wr_reg(`RN_SETUP, 8'h04);
    check({dir, asc}, 2'b01);
    done("registers");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check(dir, 1'b1);
    rst_n = 1'b1;
    foreach (dflt[i]) begin
      rd_reg(dflt[i][15:8], v);
      check(v, dflt[i][7:0]);
    end
    check({white, quart, pvalid}, 3'b000);
    done("reset");
    give_verdict();
  end
endmodule // lcd_input_timing_config_tb
